// ==== hw/pmr_pkg.sv ====
// Package: constants shared by both ends of the power and reset control link
`default_nettype none
package pmr_pkg;
	// ----------------------------------------------------------------
	// Widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 6;
	localparam int DATA_W = 8;
	localparam int HADDR_W = 3;

	// ----------------------------------------------------------------
	// Device register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] REG_RESERVED0 = 6'h00;
	localparam logic [5:0] REG_COMMAND   = 6'h01;
	localparam logic [5:0] REG_STATUS    = 6'h07;
	localparam logic [5:0] REG_MISC      = 6'h0C;
	localparam logic [5:0] REG_ANTENNA   = 6'h14;

	// ----------------------------------------------------------------
	// Fields and reset values
	// ----------------------------------------------------------------
	localparam int CMD_SLEEP_BIT = 4;
	localparam int ANT_EN1_BIT   = 0;
	localparam int ANT_EN2_BIT   = 1;
	localparam int MISC_WO_BIT   = 7;
	localparam logic [3:0] CMD_IDLE     = 4'h0;
	localparam logic [7:0] ANT_RST      = 8'h80;
	localparam logic [7:0] RESERVED_VAL = 8'h00;
	localparam logic [7:0] NOTRDY_VAL   = 8'hFF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SPIKE_NS      = 10;
	localparam int SPIKE_CYC     = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_LOW_NS    = 100;
	localparam int RST_LOW_CYC   = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int EXIT_CYC      = 1024;
	localparam int STARTUP_CYC   = 1024;
	localparam int CMD_CYC       = 4;

	// ----------------------------------------------------------------
	// Host controller register offsets
	// ----------------------------------------------------------------
	localparam logic [2:0] H_ADDR   = 3'h0;
	localparam logic [2:0] H_WDATA  = 3'h1;
	localparam logic [2:0] H_CTRL   = 3'h2;
	localparam logic [2:0] H_STATUS = 3'h3;
	localparam logic [2:0] H_RDATA  = 3'h4;
	localparam logic [2:0] H_HOLD   = 3'h5;
	localparam int H_ADDR_RD_BIT = 7;
	localparam int HC_ACCESS_BIT = 0;
	localparam int HC_RESET_BIT  = 1;
	localparam int HC_WAKE_BIT   = 2;
endpackage
`default_nettype wire

// ==== hw/pmr_if.sv ====
// Interface: host port and reset pin between controller and device
`default_nettype none
interface pmr_if;
	import pmr_pkg::*;
	logic                rstpd_n;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   wdata;
	logic                wr;
	logic                rd;
	logic [DATA_W-1:0]   rdata;
	logic                rvalid;

	modport dev (input rstpd_n, addr, wdata, wr, rd, output rdata, rvalid);
	modport host (output rstpd_n, addr, wdata, wr, rd, input rdata, rvalid);
endinterface
`default_nettype wire

// ==== hw/pmr_device.sv ====
// Device end: power modes, reset filter, start-up delay and register bits
// Functional notes
// - Reset pin low: hard power-down, oscillator off
// - Hard power-down: inputs clamped except reset pin
// - Hard power-down: outputs frozen at static level
// - Sleep bit set: soft power-down at once
// - Soft power-down: inputs work, outputs hold
// - Soft power-down keeps registers and configuration
// - Sleep cleared: count 1024 clocks before exit
// - Sleep bit reads one until exit completes
// - UART host sends 55h first after wake
// - Host polls address 0 until real content
// - Either antenna enable low: drivers off
// - Reset pulses under 10 ns ignored
// - Host holds reset low at least 100 ns
// - Wait 1024 clocks after clock stable
// - Control bits changed only by host
// - Command field returns idle by hardware
// - Read-only bits ignore host writes
// - Write-only bits always read zero
// - Host writes zero to reserved bits
// - Host never changes reserved test bits
// - Sleep bit lives in command register 01h
// - Antenna enables live in register 14h
`default_nettype none
module pmr_device
	import pmr_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// Link
	pmr_if.dev        link,
	// Power and drive state
	output var  logic osc_enable,
	output var  logic hard_pd,
	output var  logic soft_pd,
	output var  logic dev_ready,
	output var  logic ant1_drive,
	output var  logic ant2_drive,
	output var  logic misc_strobe
);
	// ----------------------------------------------------------------
	// Reset pin spike filter
	// ----------------------------------------------------------------
	logic [3:0] low_cnt;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			low_cnt <= 4'h0;
			hard_pd <= 1'b0;
		end else if (link.rstpd_n) begin
			low_cnt <= 4'h0;
			hard_pd <= 1'b0;
		end else if (low_cnt < 4'(SPIKE_CYC)) begin
			low_cnt <= low_cnt + 4'h1;
		end else begin
			hard_pd <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Bus qualification
	// ----------------------------------------------------------------
	// Clamped inputs: nothing reaches the logic in hard power-down
	logic wr_ok;
	logic rd_ok;
	logic wr_cmd;
	logic ready;
	logic sleep;
	logic exiting;

	assign rd_ok  = link.rd && !hard_pd;
	// Before ready only the command register listens, so wake stays possible
	assign wr_ok  = link.wr && !hard_pd && ready;
	assign wr_cmd = link.wr && !hard_pd && link.addr == REG_COMMAND;

	// ----------------------------------------------------------------
	// Command register: sleep bit and dynamic command field
	// ----------------------------------------------------------------
	logic [3:0]  cmd_code;
	logic [2:0]  cmd_cnt;
	logic [10:0] exit_cnt;
	logic        exit_done;

	assign exit_done = exiting && exit_cnt == 11'(EXIT_CYC - 1);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			sleep   <= 1'b0;
			exiting <= 1'b0;
		end else if (hard_pd) begin
			sleep   <= 1'b0;
			exiting <= 1'b0;
		end else if (wr_cmd && link.wdata[CMD_SLEEP_BIT]) begin
			sleep   <= 1'b1;
			exiting <= 1'b0;
		end else if (wr_cmd && sleep && !exiting) begin
			exiting <= 1'b1;
		end else if (exit_done) begin
			sleep   <= 1'b0;
			exiting <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			exit_cnt <= 11'h000;
		end else if (!exiting || (wr_cmd && link.wdata[CMD_SLEEP_BIT])) begin
			exit_cnt <= 11'h000;
		end else begin
			exit_cnt <= exit_cnt + 11'h001;
		end
	end

	// Host write wins over the hardware return to idle
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_code <= CMD_IDLE;
			cmd_cnt  <= 3'h0;
		end else if (hard_pd) begin
			cmd_code <= CMD_IDLE;
			cmd_cnt  <= 3'h0;
		end else if (wr_cmd) begin
			cmd_code <= link.wdata[3:0];
			cmd_cnt  <= 3'h0;
		end else if (cmd_code != CMD_IDLE && !sleep) begin
			if (cmd_cnt == 3'(CMD_CYC - 1)) begin
				cmd_code <= CMD_IDLE;
				cmd_cnt  <= 3'h0;
			end else begin
				cmd_cnt <= cmd_cnt + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control registers: host-only writers
	// ----------------------------------------------------------------
	// Hard power-down restarts the device, so configuration returns to reset
	logic [7:0] ant_ctrl;
	logic       tx_on;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ant_ctrl <= ANT_RST;
		end else if (hard_pd) begin
			ant_ctrl <= ANT_RST;
		end else if (wr_ok && link.addr == REG_ANTENNA) begin
			ant_ctrl <= link.wdata;
		end
	end

	assign tx_on = ant_ctrl[ANT_EN1_BIT] && ant_ctrl[ANT_EN2_BIT];

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			misc_strobe <= 1'b0;
		end else begin
			misc_strobe <= wr_ok && link.addr == REG_MISC && link.wdata[MISC_WO_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Start-up delay and ready
	// ----------------------------------------------------------------
	logic [10:0] start_cnt;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			start_cnt <= 11'h000;
			ready     <= 1'b0;
		end else if (hard_pd || (sleep && !exit_done)) begin
			start_cnt <= 11'h000;
			ready     <= 1'b0;
		end else if (exit_done) begin
			ready <= 1'b1;
		end else if (!ready) begin
			if (start_cnt == 11'(STARTUP_CYC - 1)) begin
				ready <= 1'b1;
			end else begin
				start_cnt <= start_cnt + 11'h001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pins and power outputs
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			osc_enable <= 1'b0;
			soft_pd    <= 1'b0;
			dev_ready  <= 1'b0;
		end else begin
			osc_enable <= !hard_pd && (!sleep || exiting);
			soft_pd    <= sleep;
			dev_ready  <= ready;
		end
	end

	// Drivers freeze in either power-down and follow the enables otherwise
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ant1_drive <= 1'b0;
			ant2_drive <= 1'b0;
		end else if (!hard_pd && !sleep) begin
			ant1_drive <= tx_on;
			ant2_drive <= tx_on;
		end
	end

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	logic [7:0] next_rdata;

	always_comb begin
		next_rdata = 8'h00;
		case (link.addr)
			REG_RESERVED0: next_rdata = RESERVED_VAL;
			REG_COMMAND:   next_rdata = {3'h0, sleep, cmd_code};
			REG_STATUS:    next_rdata = {5'h00, tx_on, exiting, cmd_code != CMD_IDLE};
			REG_MISC:      next_rdata = 8'h00;
			REG_ANTENNA:   next_rdata = ant_ctrl;
			default:       next_rdata = 8'h00;
		endcase
		if (!ready) begin
			next_rdata = NOTRDY_VAL;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link.rdata  <= 8'h00;
			link.rvalid <= 1'b0;
		end else begin
			link.rvalid <= rd_ok;
			if (rd_ok) begin
				link.rdata <= next_rdata;
			end
		end
	end
endmodule // pmr_device
`default_nettype wire

// ==== hw/pmr_host.sv ====
// Host end: reset pulse, register access and wake-up polling of the device
`default_nettype none
module pmr_host
	import pmr_pkg::*;
(
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               rstn,
	// Software port
	input  wire logic [HADDR_W-1:0] u_addr,
	input  wire logic [7:0]         u_wdata,
	input  wire logic               u_wr,
	input  wire logic               u_rd,
	output var  logic [7:0]         u_rdata,
	// Link
	pmr_if.host                     link
);
	typedef enum logic [2:0] {HS_IDLE, HS_RST, HS_ACC, HS_WAIT, HS_WAKE, HS_POLL, HS_PWAIT}
		pmr_hstate_t;

	pmr_hstate_t state;
	logic [7:0]  acc_addr;
	logic [7:0]  acc_wdata;
	logic [7:0]  acc_rdata;
	logic        hold_low;
	logic        seen_ready;
	logic [3:0]  rst_cnt;
	logic        go_acc;
	logic        go_rst;
	logic        go_wake;

	assign go_acc  = u_wr && u_addr == H_CTRL && u_wdata[HC_ACCESS_BIT];
	assign go_rst  = u_wr && u_addr == H_CTRL && u_wdata[HC_RESET_BIT];
	assign go_wake = u_wr && u_addr == H_CTRL && u_wdata[HC_WAKE_BIT];

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			acc_addr  <= 8'h00;
			acc_wdata <= 8'h00;
			hold_low  <= 1'b0;
		end else if (u_wr) begin
			if (u_addr == H_ADDR) acc_addr <= u_wdata;
			if (u_addr == H_WDATA) acc_wdata <= u_wdata;
			if (u_addr == H_HOLD) hold_low <= u_wdata[0];
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			u_rdata <= 8'h00;
		end else if (u_rd) begin
			case (u_addr)
				H_ADDR:   u_rdata <= acc_addr;
				H_WDATA:  u_rdata <= acc_wdata;
				H_STATUS: u_rdata <= {6'h00, seen_ready, state != HS_IDLE};
				H_RDATA:  u_rdata <= acc_rdata;
				H_HOLD:   u_rdata <= {7'h00, hold_low};
				default:  u_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Polling has no limit: a device held in power-down keeps it busy
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state      <= HS_IDLE;
			rst_cnt    <= 4'h0;
			seen_ready <= 1'b0;
			acc_rdata  <= 8'h00;
		end else begin
			case (state)
				HS_IDLE: begin
					rst_cnt <= 4'h0;
					if (go_rst) begin
						state      <= HS_RST;
						seen_ready <= 1'b0;
					end else if (go_wake) begin
						state      <= HS_WAKE;
						seen_ready <= 1'b0;
					end else if (go_acc) begin
						state <= HS_ACC;
					end
				end
				HS_RST: begin
					rst_cnt <= rst_cnt + 4'h1;
					if (rst_cnt == 4'(RST_LOW_CYC - 1)) state <= HS_POLL;
				end
				HS_ACC:  state <= acc_addr[H_ADDR_RD_BIT] ? HS_WAIT : HS_IDLE;
				HS_WAIT: begin
					if (link.rvalid) begin
						acc_rdata <= link.rdata;
						state     <= HS_IDLE;
					end
				end
				HS_WAKE: state <= HS_POLL;
				HS_POLL: state <= HS_PWAIT;
				HS_PWAIT: begin
					if (link.rvalid && link.rdata == RESERVED_VAL) begin
						seen_ready <= 1'b1;
						state      <= HS_IDLE;
					end else if (link.rvalid) begin
						state <= HS_POLL;
					end
				end
				default: state <= HS_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Link drive
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			link.rstpd_n <= 1'b1;
			link.addr    <= 6'h00;
			link.wdata   <= 8'h00;
			link.wr      <= 1'b0;
			link.rd      <= 1'b0;
		end else begin
			link.rstpd_n <= !(hold_low || (state == HS_IDLE && go_rst) ||
				(state == HS_RST && rst_cnt != 4'(RST_LOW_CYC - 1)));
			link.wr      <= 1'b0;
			link.rd      <= 1'b0;
			if (state == HS_IDLE && go_wake) begin
				link.addr  <= REG_COMMAND;
				link.wdata <= 8'h00;
				link.wr    <= 1'b1;
			end else if (state == HS_IDLE && go_acc) begin
				link.addr  <= acc_addr[5:0];
				link.wdata <= acc_wdata;
				link.wr    <= !acc_addr[H_ADDR_RD_BIT];
				link.rd    <= acc_addr[H_ADDR_RD_BIT];
			end else if (state == HS_POLL) begin
				link.addr <= REG_RESERVED0;
				link.rd   <= 1'b1;
			end
		end
	end
endmodule // pmr_host
`default_nettype wire

// ==== verification/pmr_assertions.sv ====
// Checker: link properties between the host and device ends
`default_nettype none
module pmr_assertions
	import pmr_pkg::*;
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rstn,
	// Link
	input wire logic              rstpd_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic              wr,
	input wire logic              rd,
	input wire logic [DATA_W-1:0] rdata,
	input wire logic              rvalid
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	// ----
	// Readiness tracker
	// ----
	// Margins around the 1024-cycle count keep clear of the exact exit edge
	logic [10:0] cnt;
	logic        sl;
	logic        wr_cmd;
	assign wr_cmd = wr && addr == REG_COMMAND;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			cnt <= 11'h000;
		else if (!rstpd_n || (wr_cmd && sl && !wdata[CMD_SLEEP_BIT]))
			cnt <= 11'h000;
		else if (cnt != 11'h7FF)
			cnt <= cnt + 11'h001;
	end
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn)
			sl <= 1'b0;
		else if (!rstpd_n)
			sl <= 1'b0;
		else if (wr_cmd)
			sl <= wdata[CMD_SLEEP_BIT];
	end
	// ----
	// Properties
	// ----
	pulse_width_a: assert property ($fell(rstpd_n) |-> !rstpd_n[*8] ##1 !rstpd_n[*2])
		else $error("reset pin pulse too short");
	read_answer_a: assert property (rstpd_n[*3] ##0 rd |=> rvalid)
		else $error("read got no answer");
	answer_cause_a: assert property (rvalid |-> $past(rd))
		else $error("answer without a read");
	hard_silent_a: assert property (!rstpd_n[*4] |-> !rvalid)
		else $error("answer during hard power-down");
	rdata_hold_a: assert property (!rvalid |-> $stable(rdata))
		else $error("read data moved without an answer");
	not_ready_a: assert property (
		rvalid && (sl || cnt < 11'h3E8) |-> rdata == NOTRDY_VAL)
		else $error("access answered before ready");
	zero_reads_a: assert property (rvalid && !sl && cnt > 11'h44C &&
		($past(addr) == REG_RESERVED0 || $past(addr) == REG_MISC) |-> rdata == 8'h00)
		else $error("reserved or write-only read not zero");
	poll_start_a: assert property ($rose(rstpd_n) |-> ##[1:20] (rd && addr == REG_RESERVED0))
		else $error("no poll after reset pulse");
	cover property (rvalid && rdata == RESERVED_VAL);
	cover property ($fell(rstpd_n));
	cover property (wr_cmd && wdata[CMD_SLEEP_BIT]);
endmodule // pmr_assertions
`default_nettype wire

// ==== verification/testbench.sv ====
// Testbench: host and device ends joined by the link, driven from the software port
`default_nettype none
module testbench
	import pmr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Signals and instances
	// ----
	logic               clk     = 1'b0;
	logic               rstn    = 1'b0;
	logic [HADDR_W-1:0] u_addr  = '0;
	logic [7:0]         u_wdata = '0;
	logic               u_wr    = 1'b0;
	logic               u_rd    = 1'b0;
	logic [7:0]         u_rdata;
	logic               osc_enable, hard_pd, soft_pd, dev_ready;
	logic               ant1_drive, ant2_drive, misc_strobe;
	logic               rd_seen = 1'b0;
	logic [15:0]        notes[$];
	int                 bad_count = 0;
	int                 checks    = 0;
	int                 misc_pulses = 0;

	always #5 clk = ~clk;

	pmr_if pmr_if_inst ();
	pmr_device pmr_device_inst (.clk(clk), .rstn(rstn), .link(pmr_if_inst.dev),
		.osc_enable(osc_enable), .hard_pd(hard_pd), .soft_pd(soft_pd), .dev_ready(dev_ready),
		.ant1_drive(ant1_drive), .ant2_drive(ant2_drive), .misc_strobe(misc_strobe));
	pmr_host pmr_host_inst (.clk(clk), .rstn(rstn), .u_addr(u_addr), .u_wdata(u_wdata),
		.u_wr(u_wr), .u_rd(u_rd), .u_rdata(u_rdata), .link(pmr_if_inst.host));
	pmr_assertions pmr_assertions_inst (.clk(clk), .rstn(rstn), .rstpd_n(pmr_if_inst.rstpd_n),
		.addr(pmr_if_inst.addr), .wdata(pmr_if_inst.wdata), .wr(pmr_if_inst.wr),
		.rd(pmr_if_inst.rd), .rdata(pmr_if_inst.rdata), .rvalid(pmr_if_inst.rvalid));
	// ----
	// Tasks
	// ----
	task automatic wrap_up();
		// A read still queued here never got compared
		if (notes.size() != 0)
			fail("read result never arrived");
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic fail(input string msg);
		$display("[ERR] %0t %s", $time, msg);
		bad_count++;
	endtask
	// Note holds {mask, expected}
	task automatic cmp8(input logic [7:0] got, input logic [15:0] note);
		checks++;
		if ((got & note[15:8]) !== note[7:0])
			fail("read data mismatch");
	endtask
	task automatic cmp1(input logic got, input logic exp);
		#1;
		checks++;
		if (got !== exp)
			fail("output level mismatch");
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// A gap edge before each strobe keeps every signal to one assignment per step
	task automatic sw_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		u_addr  <= a;
		u_wdata <= d;
		u_wr    <= 1'b1;
		@(posedge clk);
		u_wr <= 1'b0;
	endtask
	task automatic sw_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
		@(posedge clk);
		u_addr <= a;
		u_rd   <= 1'b1;
		notes.push_back({m, e & m});
		@(posedge clk);
		u_rd <= 1'b0;
	endtask
	task automatic peek(input logic [2:0] a, output logic [7:0] v);
		@(posedge clk);
		u_addr <= a;
		u_rd   <= 1'b1;
		@(posedge clk);
		u_rd <= 1'b0;
		#1;
		v = u_rdata;
	endtask
	task automatic dev_op(input logic rdn, input logic [5:0] a, input logic [7:0] d);
		sw_wr(H_ADDR, {rdn, 1'b0, a});
		if (!rdn)
			sw_wr(H_WDATA, d);
		sw_wr(H_CTRL, 8'h01 << HC_ACCESS_BIT);
		repeat (6) @(posedge clk);
	endtask
	task automatic dev_rd(input logic [5:0] a, input logic [7:0] m, input logic [7:0] e);
		dev_op(1'b1, a, 8'h00);
		sw_rd(H_RDATA, m, e);
	endtask
	task automatic host_cmd(input int b);
		sw_wr(H_CTRL, 8'h01 << b);
	endtask
	// Status: busy low and ready seen
	task automatic wait_ready();
		logic [7:0] v;
		for (int i = 0; i < 2000; i++) begin
			peek(H_STATUS, v);
			if (v[1:0] === 2'b10)
				return;
		end
		fail("timeout waiting for ready");
		wrap_up();
	endtask
	// Results arrive one cycle after the strobe
	always @(posedge clk) begin
		if (rd_seen && notes.size() != 0)
			cmp8(u_rdata, notes.pop_front());
		if (misc_strobe === 1'b1)
			misc_pulses <= misc_pulses + 1;
		rd_seen <= u_rd;
	end
	// ----
	// Sequence
	// ----
	initial begin
		logic [7:0] d;
		int         n;
		void'($urandom(49));
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		dev_rd(REG_RESERVED0, 8'hFF, NOTRDY_VAL);
		host_cmd(HC_RESET_BIT);
		step(6);
		cmp1(hard_pd, 1'b1);
		cmp1(osc_enable, 1'b0);
		wait_ready();
		cmp1(dev_ready, 1'b1);
		dev_rd(REG_RESERVED0, 8'hFF, RESERVED_VAL);
		dev_rd(REG_ANTENNA, 8'hFF, ANT_RST);
		for (int i = 0; i < 4; i++) begin
			d = (8'($urandom()) & 8'hFC) | 8'(i);
			dev_op(1'b0, REG_ANTENNA, d);
			dev_rd(REG_ANTENNA, 8'hFF, d);
			cmp1(ant1_drive, i == 3);
			cmp1(ant2_drive, i == 3);
		end
		dev_op(1'b0, REG_STATUS, 8'hFF);
		// Both enables set, no command running, no exit count
		dev_rd(REG_STATUS, 8'hFF, 8'h04);
		dev_op(1'b0, REG_MISC, 8'h80);
		dev_rd(REG_MISC, 8'hFF, 8'h00);
		cmp1(misc_pulses == 1, 1'b1);
		dev_rd(6'h20 | 6'($urandom() % 16), 8'hFF, 8'h00);
		dev_op(1'b0, REG_COMMAND, 8'(1 + $urandom() % 15));
		dev_rd(REG_COMMAND, 8'hFF, {4'h0, CMD_IDLE});
		dev_op(1'b0, REG_COMMAND, 8'h10);
		cmp1(soft_pd, 1'b1);
		cmp1(ant1_drive, 1'b1);
		dev_rd(REG_ANTENNA, 8'hFF, NOTRDY_VAL);
		dev_op(1'b0, REG_COMMAND, 8'h00);
		step(500);
		dev_op(1'b0, REG_COMMAND, 8'h10);
		step(1100);
		cmp1(soft_pd, 1'b1);
		host_cmd(HC_WAKE_BIT);
		n = 0;
		while (soft_pd === 1'b1 && n < 1200) begin
			step(1);
			n++;
		end
		cmp1(n >= 1018 && n <= 1034, 1'b1);
		wait_ready();
		dev_rd(REG_ANTENNA, 8'hFF, d);
		cmp1(ant2_drive, 1'b1);
		// Pin held low by software: driver 1 must stay frozen at its last level
		sw_wr(H_HOLD, 8'h01);
		step(12);
		cmp1(hard_pd, 1'b1);
		cmp1(osc_enable, 1'b0);
		cmp1(ant1_drive, 1'b1);
		sw_rd(H_HOLD, 8'hFF, 8'h01);
		sw_wr(H_HOLD, 8'h00);
		host_cmd(HC_RESET_BIT);
		step(12);
		wait_ready();
		dev_rd(REG_ANTENNA, 8'hFF, ANT_RST);
		cmp1(ant1_drive, 1'b0);
		// Let the last queued read reach its compare
		step(2);
		wrap_up();
	end
endmodule // testbench
`default_nettype wire
